/* include/pnp_consts.vh */
`ifndef PNP_CONSTS_VH
`define PNP_CONSTS_VH
// register word indices and byte addresses
`define PNP_IDX_PARTNER_PAGE   8'h05
`define PNP_ADDR_PARTNER_PAGE  8'h14
`define PNP_ADDR_PAGE_STATUS   8'h18
// field positions of the partner page word
`define PNP_BIT_MORE_PAGES     15
`define PNP_BIT_ACK            14
`define PNP_BIT_FORMATTED      13
`define PNP_BIT_CAN_COMPLY     12
`define PNP_BIT_TOGGLE         11
`define PNP_CODE_MSB           10
// status register bit
`define PNP_BIT_PAGE_RX        1
// reset values
`define PNP_RST_PAGE           16'h0000
`define PNP_UNMAPPED_DATA      32'h00000000
`endif

/* verilog/pnp_capture.v */
`include "pnp_consts.vh"
`default_nettype none
module pnp_capture (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        page_valid,
  input  wire [15:0] page_word,
  input  wire        status_read,
  output reg  [15:0] page_q,
  output reg         page_rx_q
);
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      page_q    <= `PNP_RST_PAGE;
      page_rx_q <= 1'b0;
    end
    else
    begin
      if (page_valid)
      begin
        page_q <= page_word;
      end
      if (page_valid)
      begin
        page_rx_q <= 1'b1;
      end
      else if (status_read)
      begin
        page_rx_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* verilog/pnp_partner_page.v */
// Chosen here: the Avalon-MM slave port.
`include "pnp_consts.vh"
// Function
// - bit 15 shows whether the partner asks for a further next page.
// - bit 14 shows whether the partner acknowledged our ability word.
// - the negotiation logic alone updates the acknowledge bit from received bursts.
// - bits 10:0 hold the partner code, formatted when bit 13 is set, unformatted otherwise.
// - bit 12 shows whether the partner can comply with the message.
// - bit 11 shows the inverse of the toggle of the previously sent code word.
// - a received page sets a latched page-received bit that a status read returning it set clears; a page in the same cycle wins.
`default_nettype none
module pnp_partner_page (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        rx_page_valid,
  input  wire        rx_more_pages_wanted,
  input  wire        rx_ack,
  input  wire        rx_formatted_message_flag,
  input  wire        rx_partner_can_comply,
  input  wire        prev_tx_toggle,
  input  wire [10:0] rx_code
);
  // access sequencer states
  localparam [0:0] ST_IDLE   = 1'h0;
  localparam [0:0] ST_ANSWER = 1'h1;

  // read source select codes
  localparam [1:0] SEL_NONE   = 2'h0;
  localparam [1:0] SEL_PAGE   = 2'h1;
  localparam [1:0] SEL_STATUS = 2'h2;

  wire [15:0] page_q;
  wire        page_rx_q;
  reg  [15:0] page_word;
  reg  [0:0]  state_q;
  reg  [0:0]  state_d;
  reg  [31:0] readdata_d;
  reg  [1:0]  read_sel;
  reg         wait_cycle;
  reg         answer_cycle;
  wire        request;
  wire        hit_page;
  wire        hit_status;
  wire        read_done;
  wire        page_seen;
  wire        status_read;

  // byte address decode, shared by the read mux and the clear strobe
  function is_page_addr;
    input [7:0] addr;
    begin
      is_page_addr = (addr == `PNP_ADDR_PARTNER_PAGE);
    end
  endfunction

  function is_status_addr;
    input [7:0] addr;
    begin
      is_status_addr = (addr == `PNP_ADDR_PAGE_STATUS);
    end
  endfunction

  // page register as seen on the 32-bit bus, upper half zero
  function [31:0] page_bus_word;
    input [15:0] page;
    begin
      page_bus_word = {16'h0000, page};
    end
  endfunction

  // status register with only the page-received flag populated
  function [31:0] status_bus_word;
    input flag;
    begin
      status_bus_word                   = `PNP_UNMAPPED_DATA;
      status_bus_word[`PNP_BIT_PAGE_RX] = flag;
    end
  endfunction

  // received page laid out by field; toggle is stored inverted
  always @*
  begin
    page_word                      = `PNP_RST_PAGE;
    page_word[`PNP_BIT_MORE_PAGES] = rx_more_pages_wanted;
    page_word[`PNP_BIT_ACK]        = rx_ack;
    page_word[`PNP_BIT_FORMATTED]  = rx_formatted_message_flag;
    page_word[`PNP_BIT_CAN_COMPLY] = rx_partner_can_comply;
    page_word[`PNP_BIT_TOGGLE]     = ~prev_tx_toggle;
    page_word[`PNP_CODE_MSB:0]     = rx_code;
  end

  assign request    = avs_read | avs_write;
  assign hit_page   = is_page_addr(avs_address);
  assign hit_status = is_status_addr(avs_address);

  // next state: every request gets exactly one wait cycle
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (request)
        begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // handshake decode per state
  always @*
  begin
    wait_cycle   = 1'h0;
    answer_cycle = 1'h0;
    case (state_q)
      ST_IDLE:
      begin
        wait_cycle = request;
      end
      ST_ANSWER:
      begin
        answer_cycle = request;
      end
      default:
      begin
        wait_cycle = 1'h0;
      end
    endcase
  end

  assign avs_waitrequest = wait_cycle;
  assign read_done       = avs_read & answer_cycle;

  // clear only a flag that the completing read really returned, so a page
  // landing between capture and completion is not lost
  assign page_seen   = avs_readdata[`PNP_BIT_PAGE_RX];
  assign status_read = read_done & hit_status & page_seen;

  // source of the read word
  always @*
  begin
    read_sel = SEL_NONE;
    if (hit_page)
    begin
      read_sel = SEL_PAGE;
    end
    else if (hit_status)
    begin
      read_sel = SEL_STATUS;
    end
  end

  // read word captured in the wait cycle, held until the next read
  always @*
  begin
    readdata_d = avs_readdata;
    if (avs_read & wait_cycle)
    begin
      case (read_sel)
        SEL_PAGE:
        begin
          readdata_d = page_bus_word(page_q);
        end
        SEL_STATUS:
        begin
          readdata_d = status_bus_word(page_rx_q);
        end
        default:
        begin
          readdata_d = `PNP_UNMAPPED_DATA;
        end
      endcase
    end
  end

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q      <= ST_IDLE;
      avs_readdata <= `PNP_UNMAPPED_DATA;
    end
    else
    begin
      state_q      <= state_d;
      avs_readdata <= readdata_d;
    end
  end

  // writes complete after one wait cycle and change no field; the acknowledge
  // bit is only ever loaded from received pages

  pnp_capture u_cap (
    .clk_sys     (clk_sys),
    .rst         (rst),
    .page_valid  (rx_page_valid),
    .page_word   (page_word),
    .status_read (status_read),
    .page_q      (page_q),
    .page_rx_q   (page_rx_q)
  );
endmodule
`default_nettype wire

/* sim/pnp_sva.sv */
`include "pnp_consts.vh"
`default_nettype none
module pnp_sva (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic        rx_page_valid,
  input wire logic        rx_more_pages_wanted,
  input wire logic        rx_ack,
  input wire logic        rx_formatted_message_flag,
  input wire logic        rx_partner_can_comply,
  input wire logic        prev_tx_toggle,
  input wire logic [10:0] rx_code
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] page_model_q;
  logic        flag_model_q;
  logic        done_page;
  logic        done_status;
  logic        done_other;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  assign done_page   = avs_read && !avs_waitrequest && avs_address == `PNP_ADDR_PARTNER_PAGE;
  assign done_status = avs_read && !avs_waitrequest && avs_address == `PNP_ADDR_PAGE_STATUS;
  assign done_other  = avs_read && !avs_waitrequest && !done_page && !done_status;
  // reference page and received flag kept from the partner's pages
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      page_model_q <= 16'h0000;
      flag_model_q <= 1'b0;
    end
    else
    begin
      if (rx_page_valid)
        page_model_q <= {rx_more_pages_wanted, rx_ack, rx_formatted_message_flag,
                         rx_partner_can_comply, ~prev_tx_toggle, rx_code};
      if (rx_page_valid)
        flag_model_q <= 1'b1;
      else if (done_status && avs_readdata[`PNP_BIT_PAGE_RX])
        flag_model_q <= 1'b0;
    end
  end
  a_idle_no_wait: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  a_wait_bounded: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  a_page_readback: assert property (done_page |-> avs_readdata == {16'h0000, $past(page_model_q)})
    else $error("page read wrong");
  a_status_readback: assert property (done_status |-> avs_readdata == {30'h0, $past(flag_model_q), 1'b0})
    else $error("status read wrong");
  a_unmapped_zero: assert property (done_other |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait count wrong");
  a_write_ignored: assert property (avs_write |=> $stable(avs_readdata))
    else $error("write changed data");
endmodule
`default_nettype wire

/* sim/pnp_far.sv */
`default_nettype none
module pnp_far (
  input wire logic         clk_sys,
  input wire logic         go,
  output var logic         v,
  output var logic  [15:0] w
);
  timeunit 1ns;
  timeprecision 1ns;
  // page held only while valid, inverted after
  always @(posedge clk_sys)
  begin
    v <= go;
    w <= go ? 16'($urandom) : ~w;
  end
endmodule
`default_nettype wire

/* sim/pnp_partner_page_bench.sv */
`default_nettype none
module pnp_partner_page_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, rd = 0, wr = 0, go = 0, v, wt;
  logic [7:0] ad = 8'h00;
  logic [15:0] w, pg;
  logic [31:0] rdat, exp_q[$];
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'h0;
  int fail_count = 0, total_checks = 0, cyc = 0;
  pnp_far u_pnp_far (.clk_sys, .go, .v, .w);
  pnp_partner_page u_pnp_partner_page (.clk_sys, .rst, .avs_address(ad), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wt), .rx_page_valid(v), .rx_more_pages_wanted(w[15]), .rx_ack(w[14]),
    .rx_formatted_message_flag(w[13]), .rx_partner_can_comply(w[12]),
    .prev_tx_toggle(w[11]), .rx_code(w[10:0]));
  initial forever #2 clk_sys = ~clk_sys;
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task check_read(input logic [31:0] got, input logic [31:0] want);
    total_checks++;
    if (got !== want)
    begin
      fail_count++;
      $display("wrong value %0t %h %h", $time, got, want);
    end
  endtask
  task acc(input logic [7:0] a, input logic wen, input logic [31:0] e);
    if (!wen) exp_q.push_back(e);
    ad <= a;
    rd <= !wen;
    wr <= wen;
    wd <= $urandom() & 32'hFFFFBFFF;
    be <= 4'($urandom());
    do @(posedge clk_sys); while (wt !== 1'b0);
    rd <= 0;
    wr <= 0;
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
  begin
    if (v) pg <= {w[15:12], ~w[11], w[10:0]};
    if (++cyc > 3000) fail_count++;
    if (cyc > 3000) print_verdict;
    if (rd && !wt)
    begin
      if (exp_q.size() == 0) fail_count++;
      else check_read(rdat, exp_q.pop_front());
    end
  end
  initial
  begin
    void'($urandom(90479));
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    acc(8'h14, 0, 32'h0);
    acc(8'h18, 0, 32'h0);
    repeat (4)
    begin
      go <= 1;
      @(posedge clk_sys);
      go <= 0;
      repeat (2) @(posedge clk_sys);
      acc(8'h14, 0, pg);
      acc(8'h18, 1, 32'h0);
      acc(8'h18, 0, 32'h2);
      acc(8'h18, 0, 32'h0);
      acc(8'h14, 1, 32'h0);
      acc(8'h14, 0, pg);
      acc(8'h40, 0, 32'h0);
    end
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    acc(8'h14, 0, 32'h0);
    acc(8'h18, 0, 32'h0);
    print_verdict;
  end
endmodule
bind pnp_partner_page pnp_sva u_pnp_sva (.clk_sys(clk_sys), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .rx_page_valid(rx_page_valid), .rx_more_pages_wanted(rx_more_pages_wanted),
  .rx_ack(rx_ack), .rx_formatted_message_flag(rx_formatted_message_flag),
  .rx_partner_can_comply(rx_partner_can_comply), .prev_tx_toggle(prev_tx_toggle),
  .rx_code(rx_code));
`default_nettype wire
